/* File: design/grb_avg_filter.sv */
// Purpose: Moving average of the cell voltage over a fixed window
// Assumes: One sample strobe per SAMPLE_S seconds from the gauge core
// Notes:   Power-of-two sample count keeps the divide a shift
module grb_avg_filter
    import grb_pkg::*;
#(
    parameter int DEPTH_LOG2 = 4
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sample_stb,
    input  wire logic [15:0] sample,
    output logic      [15:0] average
);
    localparam int DEPTH = 1 << DEPTH_LOG2;
    localparam int SUM_W = 16 + DEPTH_LOG2;

    // Refuse depths that the history and running sum cannot serve
    if (DEPTH_LOG2 < 1 || DEPTH_LOG2 > 8) begin
        $error("DEPTH_LOG2 out of range");
    end

    typedef struct packed {
        logic [DEPTH-1:0][15:0]   hist;
        logic [DEPTH_LOG2-1:0]    ptr;
        logic [SUM_W-1:0]         sum;
        logic [15:0]              avg;
    } grb_filt_st_t;

    grb_filt_st_t st_r;
    grb_filt_st_t st_nxt;

    // ----------------------------------------------------------------
    // Running sum: add newest, drop oldest, one slot per strobe
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (sample_stb) begin
            st_nxt.sum = st_r.sum + SUM_W'(sample) - SUM_W'(st_r.hist[st_r.ptr]);
            st_nxt.hist[st_r.ptr] = sample;
            st_nxt.ptr = st_r.ptr + 1'b1;
            st_nxt.avg = st_nxt.sum[SUM_W-1:DEPTH_LOG2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign average = st_r.avg;
endmodule

/* File: design/grb_pkg.sv */
// Purpose: Shared constants and carriers for the gauge readback register bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Printed offsets are not multiples of four, so byte address = 4 * index
package grb_pkg;

    // ----------------------------------------------------------------
    // Register indices and byte address width
    // ----------------------------------------------------------------
    localparam logic [7:0] GRB_IDX_AVG_LO   = 8'h61;
    localparam logic [7:0] GRB_IDX_CELL_HI  = 8'h62;
    localparam logic [7:0] GRB_IDX_CELL_LO  = 8'h63;
    localparam logic [7:0] GRB_IDX_TTE_HI   = 8'h64;
    localparam logic [7:0] GRB_IDX_TTE_LO   = 8'h65;
    localparam logic [7:0] GRB_IDX_SOC_HI   = 8'h66;
    localparam logic [7:0] GRB_IDX_SOC_LO   = 8'h67;
    localparam logic [7:0] GRB_IDX_TTF_HI   = 8'h68;
    localparam logic [7:0] GRB_IDX_TTF_LO   = 8'h69;
    localparam logic [7:0] GRB_IDX_READY    = 8'h6A;
    localparam int         GRB_ADDR_W       = 10;

    // ----------------------------------------------------------------
    // Ready register fields and reset values
    // ----------------------------------------------------------------
    localparam int         GRB_BIT_PORT_RDY = 7;
    localparam int         GRB_BIT_SNIF_EN  = 5;
    localparam int         GRB_NUM_VALID    = 5;
    localparam logic       GRB_SNIF_EN_RST  = 1'b1;
    localparam logic [7:0] GRB_BYTE_RST     = 8'h00;
    localparam logic [15:0] GRB_WORD_RST    = 16'h0000;

    // ----------------------------------------------------------------
    // Scaling of the quantities for software; not used in logic
    // ----------------------------------------------------------------
    localparam real GRB_AVG_WINDOW_S   = 45.0;
    localparam real GRB_VOLT_LSB_UV    = 78.125;
    localparam real GRB_VOLT_FS_V      = 5.12;
    localparam real GRB_TIME_LSB_S     = 5.625;
    localparam real GRB_TIME_FS_H      = 102.4;
    localparam real GRB_SOC_LSB_PCT    = 0.00390625;
    localparam real GRB_SOC_FS_PCT     = 256.0;

    // Validity flag order: [4] ttf, [3] soc, [2] tte, [1] cell, [0] avg
    typedef struct packed {
        logic [15:0] avg_cell_voltage;
        logic [15:0] cell_voltage;
        logic [15:0] time_empty;
        logic [15:0] charge_level;
        logic [15:0] time_full;
        logic [GRB_NUM_VALID-1:0] valid;
        logic        port_ready;
    } grb_gauge_t;

    typedef enum logic [1:0] {
        GRB_IDLE   = 2'b00,
        GRB_ACCESS = 2'b01
    } grb_phase_t;

endpackage

/* File: design/grb_regs.sv */
// Purpose: APB read-back register bank for fuel gauge results
// Assumes: Gauge core delivers results on clk with an update strobe
// Notes:   One wait state slave; unmapped addresses read zero and assert pslverr
// ----------------------------------------------------------------
// Functional notes
// - Averaged cell voltage low byte is read-only, resets to zero, and is a 45 s moving average.
// - Both cell voltages are 16-bit byte-pair joins, 78.125 uV per step, 5.12 V full scale.
// - Present cell voltage sits at 0x62 (high) and 0x63 (low), read-only, reset zero.
// - Time to empty sits at 0x64/0x65, read-only, reset zero, 5.625 s step, 102.4 h scale.
// - Time to full sits at 0x68/0x69, read-only, reset zero, same scaling as time to empty.
// - Charge level sits at 0x66/0x67, read-only, reset zero, 0.00390625 % step, 256 % scale.
// - Ready register bit 5 is a writable sniffer enable reset 1; bit 7 is read-only port ready.
// - Ready register bits 4..0 are read-only validity flags for ttf, soc, tte, cell, avg.
module grb_regs
    import grb_pkg::*;
#(
    parameter int AVG_DEPTH_LOG2 = 4
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [GRB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  gauge_upd,
    input  wire logic                  avg_sample_stb,
    input  wire grb_gauge_t            gauge_in,
    output logic                       sniffer_en,
    output logic [15:0]                avg_cell_voltage_hi_src
);
    // Refuse window sizes the averaging filter cannot serve
    if (AVG_DEPTH_LOG2 < 1 || AVG_DEPTH_LOG2 > 8) begin
        $error("AVG_DEPTH_LOG2 out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        grb_gauge_t  gauge;
        logic        snif_en;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        grb_phase_t  phase;
    } grb_st_t;

    grb_st_t     st_r;
    grb_st_t     st_nxt;
    logic [15:0] avg_value;

    // 45 s window average of the present cell voltage
    grb_avg_filter #(
        .DEPTH_LOG2 (AVG_DEPTH_LOG2)
    ) u_avg (
        .clk        (clk),
        .rst_n      (rst_n),
        .sample_stb (avg_sample_stb),
        .sample     (gauge_in.cell_voltage),
        .average    (avg_value)
    );

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Byte address to register index; misaligned gives an out-of-map index
    function automatic logic [7:0] grb_index(input logic [GRB_ADDR_W-1:0] a);
        if (a[1:0] != 2'b00) begin
            return 8'hFF;
        end
        return a[GRB_ADDR_W-1:2];
    endfunction

    function automatic logic grb_mapped(input logic [7:0] idx);
        return (idx >= GRB_IDX_AVG_LO) && (idx <= GRB_IDX_READY);
    endfunction

    // Picks the high or low byte of a 16-bit quantity
    function automatic logic [7:0] grb_half(input logic [15:0] v, input logic hi);
        return hi ? v[15:8] : v[7:0];
    endfunction

    function automatic logic [7:0] grb_read(input grb_st_t s, input logic [7:0] idx);
        logic [7:0] d;
        d = GRB_BYTE_RST;
        if (idx == GRB_IDX_AVG_LO) begin
            d = grb_half(s.gauge.avg_cell_voltage, 1'b0);
        end else if (idx == GRB_IDX_CELL_HI) begin
            d = grb_half(s.gauge.cell_voltage, 1'b1);
        end else if (idx == GRB_IDX_CELL_LO) begin
            d = grb_half(s.gauge.cell_voltage, 1'b0);
        end else if (idx == GRB_IDX_TTE_HI) begin
            d = grb_half(s.gauge.time_empty, 1'b1);
        end else if (idx == GRB_IDX_TTE_LO) begin
            d = grb_half(s.gauge.time_empty, 1'b0);
        end else if (idx == GRB_IDX_SOC_HI) begin
            d = grb_half(s.gauge.charge_level, 1'b1);
        end else if (idx == GRB_IDX_SOC_LO) begin
            d = grb_half(s.gauge.charge_level, 1'b0);
        end else if (idx == GRB_IDX_TTF_HI) begin
            d = grb_half(s.gauge.time_full, 1'b1);
        end else if (idx == GRB_IDX_TTF_LO) begin
            d = grb_half(s.gauge.time_full, 1'b0);
        end else if (idx == GRB_IDX_READY) begin
            d[GRB_BIT_PORT_RDY] = s.gauge.port_ready;
            d[GRB_BIT_SNIF_EN]  = s.snif_en;
            d[GRB_NUM_VALID-1:0] = s.gauge.valid;
        end
        return d;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Responses are registered so every bus output comes from a flop;
    // this costs one wait state per access but keeps outputs glitch free.
    always_comb begin
        logic [7:0] idx;
        idx = grb_index(paddr);
        st_nxt = st_r;
        st_nxt.ready = 1'b0;
        st_nxt.slverr = 1'b0;

        // Gauge results land only on the core's update strobe; the
        // average is ours and is copied in with the same strobe.
        if (gauge_upd) begin
            st_nxt.gauge = gauge_in;
            st_nxt.gauge.avg_cell_voltage = avg_value;
        end

        case (st_r.phase)
            GRB_IDLE: begin
                if (psel && penable) begin
                    st_nxt.ready = 1'b1;
                    st_nxt.phase = GRB_ACCESS;
                    st_nxt.slverr = !grb_mapped(idx);
                    st_nxt.rdata = '0;
                    if (!pwrite) begin
                        st_nxt.rdata = {24'h000000, grb_read(st_r, idx)};
                    end else if (idx == GRB_IDX_READY && pstrb[0]) begin
                        // Only the sniffer enable is writable here
                        st_nxt.snif_en = pwdata[GRB_BIT_SNIF_EN];
                    end
                end
            end
            GRB_ACCESS: begin
                // Handshake completed this edge; wait for next access phase
                st_nxt.phase = GRB_IDLE;
            end
            default: begin
                st_nxt.phase = GRB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= '0;
            st_r.snif_en <= GRB_SNIF_EN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata     = st_r.rdata;
    assign pready     = st_r.ready;
    assign pslverr    = st_r.slverr;
    assign sniffer_en = st_r.snif_en;
    // High byte register lives outside; it reads this held value
    assign avg_cell_voltage_hi_src = st_r.gauge.avg_cell_voltage;
endmodule

/* File: tb/grb_regs_sva.sv */
// Purpose: Concurrent checks on the gauge readback register bank ports
// Assumes: Master never overlaps a gauge_upd with the answer of a read
// Notes:   Expected bytes come from a shadow copy taken at each gauge_upd, the average low byte from avg_cell_voltage_hi_src
module grb_regs_sva
    import grb_pkg::*;
#(
    parameter int AVG_DEPTH_LOG2 = 4
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [GRB_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  gauge_upd,
    input wire logic                  avg_sample_stb,
    input wire grb_gauge_t            gauge_in,
    input wire logic                  sniffer_en,
    input wire logic [15:0]           avg_cell_voltage_hi_src
);
    // ------------------------------------------------------------
    // Shadow of captured results and expected read byte
    // ------------------------------------------------------------
    grb_gauge_t cap_r;
    logic [7:0] idx;
    logic [7:0] exp_b;
    logic       rd_done;
    logic       align;
    assign idx     = paddr[9:2];
    // Misaligned byte addresses map to nothing and must be refused
    assign align   = paddr[1:0] == 2'b00;
    assign rd_done = psel && pready && !pwrite;
    // Shadow tracks only gauge_upd, so bus traffic cannot disturb it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_r <= '0;
        end else if (gauge_upd) begin
            cap_r <= gauge_in;
        end
    end
    // Byte pairs: even index is the upper half
    always_comb begin
        case (idx)
            8'h62:   exp_b = cap_r.cell_voltage[15:8];
            8'h63:   exp_b = cap_r.cell_voltage[7:0];
            8'h64:   exp_b = cap_r.time_empty[15:8];
            8'h65:   exp_b = cap_r.time_empty[7:0];
            8'h66:   exp_b = cap_r.charge_level[15:8];
            8'h67:   exp_b = cap_r.charge_level[7:0];
            8'h68:   exp_b = cap_r.time_full[15:8];
            default: exp_b = cap_r.time_full[7:0];
        endcase
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_answer_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("answer not a single pulse one cycle after the take");
    chk_data_pairs: assert property (
        rd_done && align && idx inside {[8'h62:8'h69]} |-> prdata == {24'h0, exp_b} && !pslverr)
        else $error("byte pair read mismatch");
    chk_ready_bits: assert property (
        rd_done && align && idx == 8'h6A
        |-> prdata == {24'h0, cap_r.port_ready, 1'b0, sniffer_en, cap_r.valid})
        else $error("ready register read mismatch");
    chk_avg_low: assert property (
        rd_done && align && idx == 8'h61 |-> prdata == {24'h0, avg_cell_voltage_hi_src[7:0]})
        else $error("average low byte differs from held average");
    chk_snif_reset: assert property ($rose(rst_n) |-> sniffer_en)
        else $error("sniffer enable not set after reset");
    chk_snif_write: assert property (
        psel && penable && !pready && pwrite && align && idx == 8'h6A && pstrb[0]
        |=> sniffer_en == $past(pwdata[5]))
        else $error("sniffer enable not written");
    chk_snif_hold: assert property (!(psel && pwrite && idx == 8'h6A) |=> $stable(sniffer_en))
        else $error("sniffer enable moved without a write");
    chk_ro_no_error: assert property (
        psel && pready && pwrite && align && idx inside {[8'h61:8'h6A]} |-> !pslverr)
        else $error("write to mapped register flagged");
    chk_unmapped_err: assert property (
        psel && pready && !(align && idx inside {[8'h61:8'h6A]}) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    cover property (rd_done && idx == 8'h6A);
    cover property (psel && pready && pwrite && idx == 8'h6A);
    cover property (pslverr);
endmodule

bind grb_regs grb_regs_sva #(
    .AVG_DEPTH_LOG2          (AVG_DEPTH_LOG2)
) i_grb_regs_sva (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .pstrb                   (pstrb),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .gauge_upd               (gauge_upd),
    .avg_sample_stb          (avg_sample_stb),
    .gauge_in                (gauge_in),
    .sniffer_en              (sniffer_en),
    .avg_cell_voltage_hi_src (avg_cell_voltage_hi_src)
);

/* File: tb/grb_regs_tb.sv */
// Purpose: Directed APB tests of the gauge readback register bank
// Assumes: Averaging window shortened to four samples
// Notes:   One idle cycle between transfers keeps each signal single-driven
module grb_regs_tb
    import grb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic                  gauge_upd, avg_sample_stb, sniffer_en;
    logic [GRB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata, prdata;
    logic [3:0]            pstrb;
    logic [1:0]            adr_lo;
    logic [15:0]           avg_src;
    grb_gauge_t            gauge_in;
    int                    failures, comparisons, cycles;
    logic [7:0]            pair_b [8] = '{8'hA1, 8'h5C, 8'h3B, 8'h07, 8'hC4, 8'hE9, 8'h5D, 8'h92};

    grb_regs #(.AVG_DEPTH_LOG2(2)) i_grb_regs (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gauge_upd(gauge_upd),
        .avg_sample_stb(avg_sample_stb), .gauge_in(gauge_in), .sniffer_en(sniffer_en),
        .avg_cell_voltage_hi_src(avg_src));

    // ------------------------------------------------------------
    // Clock, timeout, verdict
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run is under two hundred cycles; ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One APB transfer; waits on pready, only the run ceiling ends a hang
    task automatic xfer(input logic w, input logic [7:0] ix, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {ix, adr_lo};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Read data is compared only on reads; the error flag always
    task automatic check(input logic w, input logic [7:0] ix, input logic [31:0] wd,
                         input logic [31:0] ex, input logic eer);
        logic [31:0] d;
        logic        e;
        xfer(w, ix, wd, d, e);
        comparisons++;
        if ((!w && d !== ex) || e !== eer) begin
            failures++;
            $display("ERROR t=%0t got %h/%h exp %h/%h", $time, d, e, ex, eer);
        end
    endtask
    // Compares a design output that is not read over the bus
    task automatic compare(input logic [15:0] got, input logic [15:0] ex);
        comparisons++;
        if (got !== ex) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, ex);
        end
    endtask
    // Pushes cnt samples then captures, letting the average settle first
    task automatic avg_step(input int cnt, input logic [15:0] ex);
        avg_sample_stb <= 1'b1;
        repeat (cnt) @(posedge clk);
        avg_sample_stb <= 1'b0;
        repeat (5) @(posedge clk);
        gauge_upd <= 1'b1;
        @(posedge clk);
        gauge_upd <= 1'b0;
        @(posedge clk);
        check(0, 8'h61, 0, {24'h0, ex[7:0]}, 0);
        compare(avg_src, ex);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, gauge_upd, avg_sample_stb} = '0;
        {paddr, pwdata, gauge_in} = '0;
        pstrb = 4'hF;
        adr_lo = 2'b00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        compare({15'h0000, sniffer_en}, 16'h0001);
        for (logic [7:0] i = 8'h61; i <= 8'h69; i++) check(0, i, 0, 0, 0);
        check(0, 8'h6A, 0, 32'h20, 0);
        gauge_in <= '{16'h0, 16'hA15C, 16'h3B07, 16'hC4E9, 16'h5D92, 5'h15, 1'b1};
        gauge_upd <= 1'b1;
        @(posedge clk);
        gauge_upd <= 1'b0;
        @(posedge clk);
        // Writes to read-only bytes must leave them untouched
        for (int i = 0; i < 8; i++) begin
            check(1, 8'h62 + i[7:0], 32'hFF, 0, 0);
            check(0, 8'h62 + i[7:0], 0, {24'h0, pair_b[i]}, 0);
        end
        check(0, 8'h6A, 0, 32'hB5, 0);
        check(1, 8'h6A, 32'hDF, 0, 0);
        compare({15'h0000, sniffer_en}, 16'h0000);
        check(0, 8'h6A, 0, 32'h95, 0);
        check(1, 8'h6A, 32'h20, 0, 0);
        check(0, 8'h6A, 0, 32'hB5, 0);
        // A write without the low byte strobe must leave the enable set
        pstrb <= 4'hE;
        check(1, 8'h6A, 32'h0, 0, 0);
        pstrb <= 4'hF;
        check(0, 8'h6A, 0, 32'hB5, 0);
        check(0, 8'h60, 0, 0, 1);
        check(1, 8'h6B, 32'h1, 0, 1);
        // Misaligned address inside the map is refused like an unmapped one
        adr_lo = 2'b10;
        check(0, 8'h62, 0, 0, 1);
        adr_lo = 2'b00;
        // Half-filled window shows the zero history, then the full value
        gauge_in.cell_voltage <= 16'h0848;
        avg_step(2, 16'h0424);
        avg_step(2, 16'h0848);
        close_out();
    end
endmodule
